// ---- aum_cfg.svh ----
// Purpose: Offsets, field positions, reset values and counts of the user bit manager
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Definitions only
`ifndef AUM_CFG_SVH
`define AUM_CFG_SVH

// Mode codes
`define AUM_MODE_ZERO 2'h0
`define AUM_MODE_BLOCK 2'h1
`define AUM_MODE_RSVD 2'h2
`define AUM_MODE_CONS 2'h3

// Register byte offsets
`define AUM_OFS_CTRL 8'h00
`define AUM_OFS_STAT 8'h04
`define AUM_OFS_QSUB 8'h08
`define AUM_OFS_EBUF 8'h40
`define AUM_E_WORDS 12

// Control fields
`define AUM_CTRL_MODE_LSB 0
`define AUM_CTRL_INH_DE 2
`define AUM_CTRL_INH_EF 3
`define AUM_CTRL_IRQ_EN 4
`define AUM_CTRL_RESET 32'h0000_0000

// Status fields; overwrite flag cleared by writing one
`define AUM_STAT_OVF 0
`define AUM_STAT_GAP_LSB 8
`define AUM_STAT_CNT_LSB 16

// Block and consumer format counts
`define AUM_BLK_BITS 192
`define AUM_BLK_LAST 8'hBF
`define AUM_IU_LAST 3'h7
`define AUM_GAP_ZEROS 4'h9
`define AUM_MAX_FILL 4'h8
`define AUM_MIN_UNITS 8'h03
`define AUM_FIFO_AW 8
`define AUM_FIFO_FULL 9'h100

`endif

// ---- aum_pkg.sv ----
// Purpose: Types of the user bit manager
// Assumes: Counts and offsets live in aum_cfg.svh
// Notes: Transmit sequencer states for the consumer format
package aum_pkg;
    typedef logic [1:0] aum_mode_t;
    typedef enum logic [1:0] {
        AUM_TX_IDLE,
        AUM_TX_UNIT,
        AUM_TX_FILL,
        AUM_TX_GAP
    } aum_tx_e;
endpackage

// ---- aum_user_bit_mgr.sv ----
// Purpose: User bit manager: zero, block and consumer message modes
// Assumes: rx_bit_valid and tx_bit_req are one-cycle pulses, one per frame
// Notes: Block starts come with the first bit of a block on each side
`timescale 1ns/10ps
`include "aum_cfg.svh"

// Contract
// R01 - Two-bit mode selects zeros, block, reserved or consumer message FIFO.
// R02 - Zeros mode sends zero regardless of buffer or incoming user bits.
// R03 - Block mode moves whole blocks through three cascaded block memories.
// R04 - Only the middle block memory is host readable and writable.
// R05 - Host-written user data reaches the output only in block mode.
// R06 - Host buffer access always uses two-byte words.
// R07 - Byte MSB is earliest received bit and first sent.
// R08 - Byte order follows time, first byte earliest.
// R09 - A unit is eight bits: leading one then seven payload bits.
// R10 - Up to eight zeros join units; nine or more zeros end a message.
// R11 - First payload bits of units are collected into a readable register.
// R12 - Consumer units are queued in a FIFO drained at transmit timing.
// R13 - Transmission starts only once a complete message is queued.
// R14 - Only units are written; filler and gaps write nothing.
// R15 - Output filler between units equals shortest observed input filler.
// R16 - Empty FIFO sends zeros until another complete message is queued.
// R17 - An overwrite clears the whole FIFO structure synchronously.
// R18 - Overwrite raises an interrupt when enabled.
// R19 - Source pads enough zeros between messages when input rate is higher.
// R20 - Reserved code does nothing; output stays zero.
// R21 - Inhibit bits block first-to-middle and middle-to-last transfers.
// R22 - Mode field is host writable and resets to zeros mode.
// R23 - FIFO holds at least one 129-unit message.
module aum_user_bit_mgr
    import aum_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_ubit,
    input wire logic rx_bit_valid,
    input wire logic rx_block_start,
    input wire logic tx_bit_req,
    input wire logic tx_block_start,
    output logic tx_ubit,
    output logic irq
);
    // Control and status
    aum_mode_t mode;
    logic inh_de;
    logic inh_ef;
    logic irq_en;
    logic ovf_flag;
    logic [31:0] q_sub;
    logic [3:0] output_gap_len;

    // Block buffers, bit 191 is the first bit of the block
    logic [191:0] d_sh;
    logic [191:0] e_buf;
    logic [191:0] f_buf;
    logic [7:0] d_cnt;
    logic [7:0] t_idx;

    // Consumer receive parser
    logic in_unit;
    logic in_msg;
    logic skip_msg;
    logic first_pend;
    logic [7:0] u_sh;
    logic [2:0] u_cnt;
    logic [3:0] zrun;
    logic [7:0] msg_units;

    // FIFO of units, top bit marks the first unit of a message
    logic [8:0] fifo_mem [0:(1 << `AUM_FIFO_AW) - 1]; // R23
    logic [8:0] wp;
    logic [8:0] cp;
    logic [8:0] rp;
    logic [8:0] fifo_cnt;
    logic push;
    logic ovf_clr;
    logic [8:0] head;

    // Consumer transmit sequencer
    aum_tx_e tx_st;
    logic [7:0] t_sh;
    logic [3:0] t_cnt;
    logic cons_bit;
    logic blk_bit;
    logic [7:0] nxt_idx;
    logic ef_load;

    // Bus handshake
    logic bus_take;
    logic [3:0] e_word;
    logic e_hit;
    logic [31:0] next_readdata;

    assign bus_take = (avs_read || avs_write) && !avs_waitrequest;
    assign e_word = 4'((avs_address - `AUM_OFS_EBUF) >> 2);
    // Full-width compare, a truncated word index would alias high addresses
    assign e_hit = (avs_address >= `AUM_OFS_EBUF) && ((avs_address - `AUM_OFS_EBUF) < 8'(4 * `AUM_E_WORDS))
        && (avs_address[1:0] == 2'h0);
    assign fifo_cnt = wp - rp;
    assign push = rx_bit_valid && (mode == `AUM_MODE_CONS) && in_unit && (u_cnt == `AUM_IU_LAST) && !skip_msg;
    assign ovf_clr = push && (fifo_cnt == `AUM_FIFO_FULL); // R17
    assign head = fifo_mem[rp[`AUM_FIFO_AW-1:0]];

    // One wait state: waitrequest drops the cycle after a request appears
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            `AUM_OFS_CTRL: begin
                next_readdata[`AUM_CTRL_MODE_LSB +: 2] = mode;
                next_readdata[`AUM_CTRL_INH_DE] = inh_de;
                next_readdata[`AUM_CTRL_INH_EF] = inh_ef;
                next_readdata[`AUM_CTRL_IRQ_EN] = irq_en;
            end
            `AUM_OFS_STAT: begin
                next_readdata[`AUM_STAT_OVF] = ovf_flag;
                next_readdata[`AUM_STAT_GAP_LSB +: 4] = output_gap_len;
                next_readdata[`AUM_STAT_CNT_LSB +: 9] = fifo_cnt;
            end
            `AUM_OFS_QSUB: next_readdata = q_sub; // R11
            default: begin
                // Two bytes per word, earlier byte in the upper lane
                if (e_hit) begin
                    next_readdata[15:0] = e_buf[8'd191 - {e_word, 4'h0} -: 16]; // R04 R06 R08
                end
            end
        endcase
    end

    // Control register
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= `AUM_MODE_ZERO; // R22
            inh_de <= 1'b0;
            inh_ef <= 1'b0;
            irq_en <= 1'b0;
        end else if (bus_take && avs_write && (avs_address == `AUM_OFS_CTRL)) begin
            mode <= avs_writedata[`AUM_CTRL_MODE_LSB +: 2]; // R01 R22
            inh_de <= avs_writedata[`AUM_CTRL_INH_DE];
            inh_ef <= avs_writedata[`AUM_CTRL_INH_EF];
            irq_en <= avs_writedata[`AUM_CTRL_IRQ_EN];
        end
    end

    // Overwrite flag; a new overwrite beats the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_flag <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (ovf_clr) begin
                ovf_flag <= 1'b1; // R17
            end else if (bus_take && avs_write && (avs_address == `AUM_OFS_STAT) && avs_writedata[`AUM_STAT_OVF]) begin
                ovf_flag <= 1'b0;
            end
            irq <= (ovf_flag || ovf_clr) && irq_en; // R18
        end
    end

    // First buffer: shift in at the bottom so the earliest bit ends on top
    always_ff @(posedge clk) begin
        if (rst) begin
            d_sh <= '0;
            d_cnt <= 8'h00;
        end else if (rx_bit_valid) begin
            d_sh <= {d_sh[190:0], rx_ubit}; // R07
            d_cnt <= rx_block_start ? 8'h01 : ((d_cnt == `AUM_BLK_LAST) ? 8'h00 : d_cnt + 8'h01);
        end
    end

    // Middle buffer: block transfer in, host word writes win over it
    always_ff @(posedge clk) begin
        if (rst) begin
            e_buf <= '0;
        end else begin
            if (rx_bit_valid && !rx_block_start && (d_cnt == `AUM_BLK_LAST) && !inh_de) begin
                e_buf <= {d_sh[190:0], rx_ubit}; // R03 R21
            end
            if (bus_take && avs_write && e_hit) begin
                e_buf[8'd191 - {e_word, 4'h0} -: 16] <= avs_writedata[15:0]; // R04 R06
            end
        end
    end

    // Last buffer and transmit bit position
    assign ef_load = tx_block_start && !inh_ef; // R21
    assign nxt_idx = tx_block_start ? 8'h00 : ((t_idx == `AUM_BLK_LAST) ? 8'h00 : t_idx + 8'h01);
    assign blk_bit = ef_load ? e_buf[8'd191 - nxt_idx] : f_buf[8'd191 - nxt_idx]; // R07 R08

    always_ff @(posedge clk) begin
        if (rst) begin
            f_buf <= '0;
            t_idx <= `AUM_BLK_LAST;
        end else if (tx_bit_req) begin
            if (ef_load) begin
                f_buf <= e_buf; // R03
            end
            t_idx <= nxt_idx;
        end
    end

    // Consumer receive parser
    always_ff @(posedge clk) begin
        if (rst) begin
            in_unit <= 1'b0;
            in_msg <= 1'b0;
            skip_msg <= 1'b0;
            first_pend <= 1'b0;
            u_sh <= 8'h00;
            u_cnt <= 3'h0;
            zrun <= `AUM_GAP_ZEROS;
            msg_units <= 8'h00;
            output_gap_len <= `AUM_MAX_FILL;
            q_sub <= 32'h0000_0000;
            wp <= 9'h000;
            cp <= 9'h000;
        end else if (mode != `AUM_MODE_CONS) begin
            in_unit <= 1'b0;
            in_msg <= 1'b0;
            skip_msg <= 1'b0;
            zrun <= `AUM_GAP_ZEROS;
            msg_units <= 8'h00;
            wp <= cp;
        end else if (rx_bit_valid) begin
            if (in_unit) begin
                u_sh <= {u_sh[6:0], rx_ubit};
                u_cnt <= u_cnt + 3'h1;
                if (u_cnt == `AUM_IU_LAST) begin
                    in_unit <= 1'b0;
                    zrun <= 4'h0;
                    q_sub <= {q_sub[30:0], u_sh[5]}; // R11
                    if (ovf_clr) begin
                        wp <= 9'h000; // R17
                        cp <= 9'h000;
                        skip_msg <= 1'b1;
                    end else if (!skip_msg) begin
                        fifo_mem[wp[`AUM_FIFO_AW-1:0]] <= {first_pend, u_sh[6:0], rx_ubit}; // R12 R14
                        wp <= wp + 9'h001;
                        msg_units <= (msg_units == 8'hFF) ? msg_units : msg_units + 8'h01;
                    end
                end
            end else if (rx_ubit) begin
                // Start bit of a unit
                in_unit <= 1'b1; // R09
                u_sh <= 8'h01;
                u_cnt <= 3'h1;
                first_pend <= !in_msg;
                in_msg <= 1'b1;
                if (in_msg && (zrun < output_gap_len)) begin
                    output_gap_len <= zrun; // R15
                end
            end else begin
                zrun <= (zrun == `AUM_GAP_ZEROS) ? zrun : zrun + 4'h1;
                if (in_msg && (zrun == `AUM_MAX_FILL)) begin
                    // Ninth zero closes the message; short ones are dropped
                    in_msg <= 1'b0; // R10
                    skip_msg <= 1'b0;
                    msg_units <= 8'h00;
                    if (!skip_msg && (msg_units >= `AUM_MIN_UNITS)) begin
                        cp <= wp; // R13
                    end else if (!skip_msg) begin
                        wp <= cp;
                    end
                end
            end
        end
    end

    // Consumer transmit sequencer, runs only on committed units
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_st <= AUM_TX_IDLE;
            rp <= 9'h000;
            t_sh <= 8'h00;
            t_cnt <= 4'h0;
            cons_bit <= 1'b0;
        end else if (ovf_clr || (mode != `AUM_MODE_CONS)) begin
            // Restart clean; a partly sent unit is cut, not corrupted
            tx_st <= AUM_TX_IDLE; // R17
            rp <= ovf_clr ? 9'h000 : cp;
            cons_bit <= 1'b0;
        end else if (tx_bit_req) begin
            case (tx_st)
                AUM_TX_IDLE, AUM_TX_FILL: begin
                    if ((tx_st == AUM_TX_FILL) && (t_cnt != 4'h0)) begin
                        cons_bit <= 1'b0; // R15
                        t_cnt <= t_cnt - 4'h1;
                    end else if (rp != cp) begin
                        cons_bit <= head[7]; // R12 R13
                        t_sh <= {head[6:0], 1'b0};
                        t_cnt <= 4'h7;
                        rp <= rp + 9'h001;
                        tx_st <= AUM_TX_UNIT;
                    end else begin
                        cons_bit <= 1'b0; // R16
                        tx_st <= AUM_TX_IDLE;
                    end
                end
                AUM_TX_UNIT: begin
                    cons_bit <= t_sh[7];
                    t_sh <= {t_sh[6:0], 1'b0};
                    t_cnt <= t_cnt - 4'h1;
                    if (t_cnt == 4'h1) begin
                        if ((rp != cp) && !head[8]) begin
                            tx_st <= AUM_TX_FILL;
                            t_cnt <= output_gap_len; // R15
                        end else begin
                            tx_st <= AUM_TX_GAP;
                            t_cnt <= `AUM_GAP_ZEROS; // R10
                        end
                    end
                end
                AUM_TX_GAP: begin
                    cons_bit <= 1'b0;
                    t_cnt <= t_cnt - 4'h1;
                    if (t_cnt == 4'h1) begin
                        tx_st <= AUM_TX_IDLE;
                    end
                end
                default: begin
                    tx_st <= AUM_TX_IDLE;
                    cons_bit <= 1'b0;
                end
            endcase
        end
    end

    // Output bit; the consumer path has its own one-frame pipeline
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_ubit <= 1'b0;
        end else if (tx_bit_req) begin
            case (mode)
                `AUM_MODE_BLOCK: tx_ubit <= blk_bit; // R05
                `AUM_MODE_CONS: tx_ubit <= cons_bit; // R12
                default: tx_ubit <= 1'b0; // R02 R20
            endcase
        end
    end

    // Consumer mode relies on the source padding between messages, see R19 above
    a_zero_mode: assert property (@(posedge clk) disable iff (rst) // R02
        (tx_bit_req && (mode == `AUM_MODE_ZERO)) |=> !tx_ubit)
        else $error("zeros mode sent a one");

    a_rsvd_mode: assert property (@(posedge clk) disable iff (rst) // R20
        (tx_bit_req && (mode == `AUM_MODE_RSVD)) |=> !tx_ubit)
        else $error("reserved mode sent a one");

    a_mode_reset: assert property (@(posedge clk) // R22
        rst |=> (mode == `AUM_MODE_ZERO))
        else $error("mode not zero after reset");

    a_wait_state: assert property (@(posedge clk) disable iff (rst) // R06
        ((avs_read || avs_write) && avs_waitrequest) |=> (!avs_waitrequest ##1 avs_waitrequest))
        else $error("waitrequest not one cycle low");

    a_ovf_clears: assert property (@(posedge clk) disable iff (rst) // R17
        ovf_clr |=> ((wp == 9'h000) && (rp == 9'h000) && (cp == 9'h000) && ovf_flag))
        else $error("overwrite did not clear fifo");

    a_irq_follow: assert property (@(posedge clk) disable iff (rst) // R18
        (ovf_clr && irq_en) |=> irq)
        else $error("overwrite interrupt missing");

    a_fifo_bound: assert property (@(posedge clk) disable iff (rst) // R23
        (fifo_cnt <= `AUM_FIFO_FULL) && ((cp - rp) <= fifo_cnt))
        else $error("fifo pointers out of order");

    a_inhibit_de: assert property (@(posedge clk) disable iff (rst) // R21
        (inh_de && !(bus_take && avs_write)) |=> $stable(e_buf))
        else $error("middle buffer changed while inhibited");

    a_empty_zero: assert property (@(posedge clk) disable iff (rst) // R16
        ((mode == `AUM_MODE_CONS) && (tx_st == AUM_TX_IDLE) && (rp == cp) && tx_bit_req && !ovf_clr)
        |=> (!cons_bit ##1 (!tx_bit_req || !tx_ubit)))
        else $error("empty fifo sent a one");

    a_gap_bound: assert property (@(posedge clk) disable iff (rst) // R15
        output_gap_len <= `AUM_MAX_FILL)
        else $error("filler length above eight");

endmodule // aum_user_bit_mgr

// ---- aum_src_model.sv ----
// Purpose: Remote user-data source feeding the receive side of the user bit manager
// Assumes: One bit per frame, valid pulse of one cycle, at most every other cycle
// Notes: Data line carries the inverse bit between frames
`timescale 1ns/10ps
module aum_src_model (
    input wire logic clk,
    output logic rx_ubit,
    output logic rx_bit_valid,
    output logic rx_block_start
);
    initial begin
        rx_ubit = 1'b0;
        rx_bit_valid = 1'b0;
        rx_block_start = 1'b0;
    end

    task automatic put(input logic b, input logic st);
        @(posedge clk);
        rx_ubit <= b;
        rx_bit_valid <= 1'b1;
        rx_block_start <= st;
        @(posedge clk);
        rx_bit_valid <= 1'b0;
        rx_block_start <= 1'b0;
        // Stale bit would hide a late sample
        rx_ubit <= ~b;
    endtask

    task automatic unit(input logic [7:0] u);
        int i;
        for (i = 7; i >= 0; i--) begin
            put(u[i], 1'b0);
        end
    endtask

    // Caller picks the count; long runs keep the queue from overrunning
    task automatic zeros(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            put(1'b0, 1'b0);
        end
    endtask
endmodule // aum_src_model

// ---- aum_user_bit_mgr_tb.sv ----
// Purpose: Self-checking bench of the user bit manager
// Assumes: One wait state on the register bus, tx bits requested by the bench
// Notes: Consumer output is searched for its first one, since the lag is not fixed here
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module aum_user_bit_mgr_tb;
    import aum_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} aum_row_s;
    logic clk, rst, avs_read, avs_write, avs_waitrequest, tx_bit_req, tx_block_start, tx_ubit, irq;
    logic rx_ubit, rx_bit_valid, rx_block_start;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic tq[$];
    int n_mismatch, n_compared, f, i;
    aum_row_s rows [13] = '{
        '{1'b0, 8'h00, 32'h0000_0000, 32'h0000_0000},
        '{1'b0, 8'h04, 32'h0000_0000, 32'h0000_0800},
        '{1'b0, 8'h08, 32'h0000_0000, 32'h0000_0000},
        '{1'b1, 8'h40, 32'hFFFF_A55A, 32'h0000_0000},
        '{1'b0, 8'h40, 32'h0000_0000, 32'h0000_A55A},
        '{1'b1, 8'h6C, 32'h0000_1234, 32'h0000_0000},
        '{1'b0, 8'h6C, 32'h0000_0000, 32'h0000_1234},
        '{1'b1, 8'h80, 32'h0000_00FF, 32'h0000_0000},
        '{1'b0, 8'h42, 32'h0000_0000, 32'h0000_0000},
        '{1'b0, 8'h40, 32'h0000_0000, 32'h0000_A55A},
        '{1'b1, 8'h00, 32'h0000_001F, 32'h0000_0000},
        '{1'b0, 8'h00, 32'h0000_0000, 32'h0000_001F},
        '{1'b1, 8'h00, 32'h0000_0000, 32'h0000_0000}};

    aum_user_bit_mgr dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_ubit(rx_ubit), .rx_bit_valid(rx_bit_valid),
        .rx_block_start(rx_block_start), .tx_bit_req(tx_bit_req), .tx_block_start(tx_block_start),
        .tx_ubit(tx_ubit), .irq(irq));
    aum_src_model src (.clk(clk), .rx_ubit(rx_ubit), .rx_bit_valid(rx_bit_valid), .rx_block_start(rx_block_start));

    always #2 clk = ~clk;

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        q = 32'h0000_0000;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 50) begin
            n_mismatch++;
            $display("unexpected at %0t: bus hang", $time);
            complete_run();
        end else begin
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdv(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000, rd);
    endtask

    task automatic tx_run(input int n, input logic blk);
        int k;
        tq.delete();
        for (k = 0; k < n; k++) begin
            @(posedge clk);
            tx_bit_req <= 1'b1;
            tx_block_start <= blk && k == 0;
            @(posedge clk);
            tx_bit_req <= 1'b0;
            tx_block_start <= 1'b0;
            @(negedge clk);
            tq.push_back(tx_ubit);
        end
    endtask

    task automatic chk16(input logic [15:0] w);
        int k;
        for (k = 0; k < 16; k++) begin
            `CHK(tq[k], w[15-k])
        end
    endtask

    function automatic logic [7:0] pb(input int k);
        return 8'(k * 37 + 1);
    endfunction

    task automatic send_block(input logic ones);
        int k;
        logic [7:0] b;
        for (k = 0; k < 192; k++) begin
            b = pb(k / 8);
            src.put(ones | b[7 - k % 8], k == 0);
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        $display("unexpected at %0t: run too long", $time);
        complete_run();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        tx_bit_req = 1'b0;
        tx_block_start = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, rows[i].d, rd);
            if (!rows[i].wr) `CHK(rd, rows[i].e)
        end
        $display("test registers done");
        src.unit(8'hFF);
        tx_run(16, 1'b1);
        chk16(16'h0000);
        $display("test zeros done");
        wr(8'h00, 32'h0000_0001);
        send_block(1'b0);
        rdv(8'h40);
        `CHK(rd, {16'h0000, pb(0), pb(1)})
        rdv(8'h6C);
        `CHK(rd, {16'h0000, pb(22), pb(23)})
        tx_run(16, 1'b1);
        chk16({pb(0), pb(1)});
        wr(8'h00, 32'h0000_0005);
        wr(8'h40, 32'h0000_C33C);
        send_block(1'b1);
        rdv(8'h40);
        `CHK(rd, 32'h0000_C33C)
        tx_run(16, 1'b1);
        chk16(16'hC33C);
        wr(8'h00, 32'h0000_000D);
        wr(8'h40, 32'h0000_0F0F);
        tx_run(16, 1'b1);
        chk16(16'hC33C);
        wr(8'h00, 32'h0000_0002);
        tx_run(16, 1'b1);
        chk16(16'h0000);
        $display("test block done");
        wr(8'h00, 32'h0000_0003);
        src.zeros(12);
        src.unit(8'hC1);
        src.zeros(2);
        src.unit(8'h80);
        src.zeros(12);
        tx_run(16, 1'b0);
        chk16(16'h0000);
        src.unit(8'hC1);
        src.zeros(2);
        src.unit(8'h80);
        src.zeros(2);
        src.unit(8'hE5);
        tx_run(16, 1'b0);
        chk16(16'h0000);
        src.zeros(12);
        rdv(8'h08);
        `CHK(rd, 32'h0000_0015)
        rdv(8'h04);
        `CHK(rd, 32'h0003_0200)
        tx_run(60, 1'b0);
        for (f = 0; f < 23 && tq[f] !== 1'b1; f++);
        for (i = 0; i < 37; i++) begin
            `CHK(tq[f + i], ({8'hC1, 2'b00, 8'h80, 2'b00, 8'hE5, 9'h000} >> (36 - i)) & 1'b1)
        end
        rdv(8'h04);
        `CHK(rd, 32'h0000_0200)
        $display("test consumer done");
        wr(8'h00, 32'h0000_0013);
        for (i = 0; i < 260; i++) begin
            src.unit(8'h80);
        end
        src.zeros(12);
        rdv(8'h04);
        `CHK({rd[24:16], rd[0]}, 10'h001)
        `CHK(irq, 1'b1)
        wr(8'h04, 32'h0000_0001);
        rdv(8'h04);
        `CHK(rd[0], 1'b0)
        `CHK(irq, 1'b0)
        tx_run(16, 1'b0);
        chk16(16'h0000);
        $display("test overwrite done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdv(8'h00);
        `CHK(rd, 32'h0000_0000)
        rdv(8'h04);
        `CHK(rd, 32'h0000_0800)
        $display("test reset done");
        complete_run();
    end
endmodule // aum_user_bit_mgr_tb
